// file: hw/port_devctl.sv
// AXI4-Lite slave holding a switch port's device control register (bits 15:0)
// assumes one clock, AXI4-Lite master obeying the protocol, separate power-on reset
//
// Summary of operation
// - extended tag enable bit 8 ignores writes, always reads zero
// - bit 10 is writable aux-power enable, zeroed by power-on reset only, drives auxPowerEn
// - no-snoop bit 11 is read-only zero
// - read request size bits 14:12 hardwired to 000, writes ignored
// - payload size write above supported maximum stores the supported maximum
// - payload size bits 7:5 read-write, reset 000, bounded by capability field
`timescale 1ns/10ps
`default_nettype none
`include "port_devctl_defines.svh"

module port_devctl
    import port_devctl_pkg::*;
#(
    parameter logic [2:0] PAYLOAD_SUPPORTED = `PAYLOAD_SUPPORTED
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic powerOnReset,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [2:0] payloadSize,
    output logic auxPowerEn
);
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    // clamp used by the write path only; its check recomputes the bound itself
    function automatic logic [2:0] clampPayload(input logic [2:0] v);
        clampPayload = (v > PAYLOAD_SUPPORTED) ? PAYLOAD_SUPPORTED : v;
    endfunction : clampPayload

    // register decode, sized so the word index compares at its own width
    function automatic logic hitCtl(input logic [11:0] a);
        hitCtl = (a[11:2] == 10'(`DEVCTL_OFFSET >> 2));
    endfunction : hitCtl

    function automatic logic hitCap(input logic [11:0] a);
        hitCap = (a[11:2] == 10'(`CAPSIZE_OFFSET >> 2));
    endfunction : hitCap

    function automatic logic [15:0] ctlImage(input logic [2:0] p, input logic a);
        ctlImage = 16'h0000;
        ctlImage[`PAYLOAD_MSB:`PAYLOAD_LSB] = p;
        ctlImage[`AUXPWR_BIT] = a;
    endfunction : ctlImage

    // ---------------------------------------------------------------
    // write channel
    // ---------------------------------------------------------------
    wr_req_t wReq_r, wReq_nxt;
    logic awHeld_r, awHeld_nxt, wHeld_r, wHeld_nxt;
    logic bValid_r, bValid_nxt;
    logic [1:0] bResp_r, bResp_nxt;
    logic [2:0] payload_r, payload_nxt;
    logic doWrite;

    assign s_axi_awready = !awHeld_r && !bValid_r;
    assign s_axi_wready = !wHeld_r && !bValid_r;
    assign s_axi_bvalid = bValid_r;
    assign s_axi_bresp = bResp_r;
    assign payloadSize = payload_r;

    // address and data captured in either order; write commits once both held
    always_comb begin
        wReq_nxt = wReq_r;
        awHeld_nxt = awHeld_r;
        wHeld_nxt = wHeld_r;
        bValid_nxt = bValid_r;
        bResp_nxt = bResp_r;
        payload_nxt = payload_r;
        doWrite = 1'b0;
        if (s_axi_awvalid && s_axi_awready) begin
            wReq_nxt.addr = s_axi_awaddr;
            awHeld_nxt = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wReq_nxt.data = s_axi_wdata;
            wReq_nxt.strb = s_axi_wstrb;
            wHeld_nxt = 1'b1;
        end
        if (awHeld_r && wHeld_r) begin
            doWrite = 1'b1;
            awHeld_nxt = 1'b0;
            wHeld_nxt = 1'b0;
            bValid_nxt = 1'b1;
            bResp_nxt = `RESP_OKAY;
            if (hitCtl(wReq_r.addr)) begin
                // bits 8,9,11,15:12 are not stored at all
                if (wReq_r.strb[0]) begin
                    payload_nxt = clampPayload(wReq_r.data[`PAYLOAD_MSB:`PAYLOAD_LSB]);
                end
            end else if (!hitCap(wReq_r.addr)) begin
                bResp_nxt = `RESP_SLVERR;
            end
        end
        if (bValid_r && s_axi_bready) begin
            bValid_nxt = 1'b0;
        end
    end

    // ordinary reset clears the write path and payload size
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wReq_r <= '0;
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            bValid_r <= 1'b0;
            bResp_r <= `RESP_OKAY;
            payload_r <= `PAYLOAD_RESET;
        end else begin
            wReq_r <= wReq_nxt;
            awHeld_r <= awHeld_nxt;
            wHeld_r <= wHeld_nxt;
            bValid_r <= bValid_nxt;
            bResp_r <= bResp_nxt;
            payload_r <= payload_nxt;
        end
    end

    // ---------------------------------------------------------------
    // sticky aux-power enable
    // ---------------------------------------------------------------
    // on power-on reset only, so a hot reset keeps the aux-power grant
    logic aux_r, aux_nxt;
    assign auxPowerEn = aux_r;

    always_comb begin
        aux_nxt = aux_r;
        if (doWrite && hitCtl(wReq_r.addr) && wReq_r.strb[1]) begin
            aux_nxt = wReq_r.data[`AUXPWR_BIT];
        end
    end

    always_ff @(posedge clk or posedge powerOnReset) begin
        if (powerOnReset) begin
            aux_r <= `AUXPWR_RESET;
        end else begin
            aux_r <= aux_nxt;
        end
    end

    // ---------------------------------------------------------------
    // read channel
    // ---------------------------------------------------------------
    rd_rsp_t rRsp_r, rRsp_nxt;
    logic rValid_r, rValid_nxt;

    assign s_axi_arready = !rValid_r;
    assign s_axi_rvalid = rValid_r;
    assign s_axi_rdata = rRsp_r.data;
    assign s_axi_rresp = rRsp_r.resp;

    // bits 8, 11 and 14:12 fall out as zero from the image
    always_comb begin
        rRsp_nxt = rRsp_r;
        rValid_nxt = rValid_r;
        if (s_axi_arvalid && s_axi_arready) begin
            rValid_nxt = 1'b1;
            rRsp_nxt.resp = `RESP_OKAY;
            rRsp_nxt.data = 32'h0000_0000;
            if (hitCtl(s_axi_araddr)) begin
                rRsp_nxt.data = {16'h0000, ctlImage(payload_r, aux_r)};
            end else if (hitCap(s_axi_araddr)) begin
                rRsp_nxt.data = {29'h0, PAYLOAD_SUPPORTED};
            end else begin
                rRsp_nxt.resp = `RESP_SLVERR;
            end
        end else if (rValid_r && s_axi_rready) begin
            rValid_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rRsp_r <= '0;
            rValid_r <= 1'b0;
        end else begin
            rRsp_r <= rRsp_nxt;
            rValid_r <= rValid_nxt;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    logic ctlRead;
    assign ctlRead = s_axi_arvalid && s_axi_arready
        && hitCtl(s_axi_araddr);

    ext_tag_zero_a: assert property (@(posedge clk) disable iff (reset)
        ctlRead |=> s_axi_rvalid && !s_axi_rdata[`EXTTAG_BIT])
        else $error("extended tag bit read nonzero");
    no_snoop_zero_a: assert property (@(posedge clk) disable iff (reset)
        ctlRead |=> !s_axi_rdata[`NOSNOOP_BIT])
        else $error("no-snoop bit read nonzero");
    rdreq_zero_a: assert property (@(posedge clk) disable iff (reset)
        ctlRead |=> s_axi_rdata[`RDREQ_MSB:`RDREQ_LSB] == 3'h0)
        else $error("read request size nonzero");
    payload_clamp_a: assert property (@(posedge clk) disable iff (reset)
        doWrite && hitCtl(wReq_r.addr) && wReq_r.strb[0]
        |=> ($past(wReq_r.data[`PAYLOAD_MSB:`PAYLOAD_LSB]) > PAYLOAD_SUPPORTED)
            ? (payload_r == PAYLOAD_SUPPORTED)
            : (payload_r == $past(wReq_r.data[`PAYLOAD_MSB:`PAYLOAD_LSB])))
        else $error("payload size not clamped");
    payload_bound_a: assert property (@(posedge clk) disable iff (reset)
        payload_r <= PAYLOAD_SUPPORTED)
        else $error("payload size above supported");
    aux_write_a: assert property (@(posedge clk) disable iff (reset || powerOnReset)
        doWrite && hitCtl(wReq_r.addr) && wReq_r.strb[1]
        |=> auxPowerEn == $past(wReq_r.data[`AUXPWR_BIT]))
        else $error("aux power enable not written");
    aux_sticky_a: assert property (@(posedge clk) disable iff (powerOnReset)
        reset |=> auxPowerEn == $past(auxPowerEn))
        else $error("aux power enable lost on reset");
    ctl_readback_a: assert property (@(posedge clk) disable iff (reset)
        ctlRead |=> s_axi_rdata[7:5] == $past(payload_r))
        else $error("payload readback mismatch");
endmodule : port_devctl

`default_nettype wire

// file: hw/port_devctl_defines.svh
// register offsets, field positions and reset values for the device control block
// assumes inclusion by bare name from the design module
`ifndef PORT_DEVCTL_DEFINES_SVH
`define PORT_DEVCTL_DEFINES_SVH

`define DEVCTL_OFFSET 12'h000
`define CAPSIZE_OFFSET 12'h004
`define ADDR_W 12
`define PAYLOAD_LSB 5
`define PAYLOAD_MSB 7
`define EXTTAG_BIT 8
`define PHANTOM_BIT 9
`define AUXPWR_BIT 10
`define NOSNOOP_BIT 11
`define RDREQ_LSB 12
`define RDREQ_MSB 14
`define PAYLOAD_RESET 3'h0
`define AUXPWR_RESET 1'h0
`define PAYLOAD_SUPPORTED 3'h2
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: hw/port_devctl_pkg.sv
// types shared by the device control register block
// assumes the defines header is on the include path
package port_devctl_pkg;
    // ---------------------------------------------------------------
    // bus payload carriers
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } wr_req_t;

    typedef struct packed {
        logic [31:0] data;
        logic [1:0] resp;
    } rd_rsp_t;

    typedef enum logic [0:0] {ST_IDLE, ST_RESP} chan_state_t;
endpackage : port_devctl_pkg

// file: verif/cfg_master_model.sv
// AXI4-Lite master standing in for configuration software
// assumes one clock; the testbench calls wr and rd one at a time
`timescale 1ns/10ps
`default_nettype none
module cfg_master_model (
    input wire logic clk,
    output var logic [11:0] awaddr,
    output var logic awvalid,
    input wire logic awready,
    output var logic [31:0] wdata,
    output var logic [3:0] wstrb,
    output var logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output var logic bready,
    output var logic [11:0] araddr,
    output var logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output var logic rready
);
    // idle bus from time zero
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end
    // called just after a rising edge; readies and answers are judged at the rising
    // edge itself, where the slave samples the same values, and taken there
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [1:0] r);
        logic pa, pw;
        pa = 1'b1;
        pw = 1'b1;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (pa || pw) begin
            @(posedge clk);
            if (pa && awready === 1'b1) begin
                awvalid <= 1'b0;
                pa = 1'b0;
            end
            if (pw && wready === 1'b1) begin
                wvalid <= 1'b0;
                pw = 1'b0;
            end
        end
        bready <= 1'b1;
        do @(posedge clk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(posedge clk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd
endmodule : cfg_master_model
`default_nettype wire

// file: verif/port_devctl_tb.sv
// self-checking bench for the device control register block
// assumes cfg_master_model drives the register bus
`timescale 1ns/10ps
`default_nettype none
module port_devctl_tb;
    localparam logic [2:0] SUP = 3'h3; // non-default supported payload size
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic powerOnReset = 1'b1;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [2:0] payloadSize;
    logic auxPowerEn;
    int nErrors = 0;
    int cmpCount = 0;
    port_devctl #(.PAYLOAD_SUPPORTED(SUP)) u_port_devctl (.clk(clk), .reset(reset),
        .powerOnReset(powerOnReset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .payloadSize(payloadSize), .auxPowerEn(auxPowerEn));
    cfg_master_model u_cfg_master_model (.clk(clk), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
    initial forever #2 clk = ~clk;
    // -----------------------------------------------------------------
    // shared checks
    // -----------------------------------------------------------------
    function automatic logic [31:0] reg_val(input logic aux, input logic [2:0] ps);
        return {21'h0, aux, 2'h0, ps, 5'h0};
    endfunction : reg_val
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        cmpCount++;
        if (got !== exp) begin
            nErrors++;
            $display("wrong value at %0t: %s got %h", $time, m, got);
        end
    endtask : chk
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        u_cfg_master_model.rd(a, d, r);
        chk(d, e, "read data");
        chk({30'h0, r}, {30'h0, er}, "read response");
    endtask : rdchk
    task automatic wrchk(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                         input logic [1:0] er);
        logic [1:0] r;
        u_cfg_master_model.wr(a, d, s, r);
        chk({30'h0, r}, {30'h0, er}, "write response");
    endtask : wrchk
    task automatic pins(input logic aux, input logic [2:0] ps);
        @(negedge clk);
        chk({28'h0, auxPowerEn, payloadSize}, {28'h0, aux, ps}, "field outputs");
        // back on a rising edge so the next bus call starts where the master expects
        @(posedge clk);
    endtask : pins
    // -----------------------------------------------------------------
    // scenarios
    // -----------------------------------------------------------------
    task automatic t_reset_vals();
        rdchk(12'h000, 32'h0, 2'h0);
        pins(1'b0, 3'h0);
        $display("test reset values done");
    endtask : t_reset_vals
    task automatic t_write_all();
        wrchk(12'h000, 32'hFFFF_FFFF, 4'hF, 2'h0);
        rdchk(12'h000, reg_val(1'b1, SUP), 2'h0);
        pins(1'b1, SUP);
        $display("test write all ones done");
    endtask : t_write_all
    task automatic t_fields();
        wrchk(12'h000, 32'h0000_0020, 4'h1, 2'h0);
        rdchk(12'h000, reg_val(1'b1, 3'h1), 2'h0);
        wrchk(12'h000, 32'h0000_0060, 4'h3, 2'h0);
        pins(1'b0, SUP);
        wrchk(12'h000, 32'h0000_0400, 4'h2, 2'h0);
        pins(1'b1, SUP);
        $display("test field writes done");
    endtask : t_fields
    task automatic t_sticky();
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        pins(1'b1, 3'h0);
        rdchk(12'h000, reg_val(1'b1, 3'h0), 2'h0);
        @(posedge clk);
        powerOnReset <= 1'b1;
        repeat (2) @(posedge clk);
        powerOnReset <= 1'b0;
        pins(1'b0, 3'h0);
        $display("test sticky enable done");
    endtask : t_sticky
    task automatic t_map();
        rdchk(12'h004, {29'h0, SUP}, 2'h0);
        rdchk(12'h008, 32'h0, 2'h2);
        wrchk(12'h008, 32'hFFFF_FFFF, 4'hF, 2'h2);
        $display("test address map done");
    endtask : t_map
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmpCount, nErrors);
        if (nErrors == 0 && cmpCount > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : results
    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        powerOnReset <= 1'b0;
        @(posedge clk);
        t_reset_vals();
        t_write_all();
        t_fields();
        t_sticky();
        t_map();
        results();
    end
    // watchdog: tests need under a hundred cycles
    initial begin
        repeat (5000) @(posedge clk);
        nErrors++;
        $display("wrong value at %0t: watchdog expired", $time);
        results();
    end
endmodule : port_devctl_tb
`default_nettype wire
